// >>> rtl/scpb_pkg.sv
// constants, types and field layout of the smart card character block
package scpb_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [15:0] ADDR_DIV  = 16'hFE10;
  localparam logic [15:0] ADDR_PAR  = 16'hFE11;
  localparam logic [15:0] ADDR_BYTE = 16'hFE12;
  localparam logic [15:0] ADDR_PROT = 16'hFE20;
  localparam logic [15:0] ADDR_STAT = 16'hFE21;

  localparam logic [7:0] DIV_RST  = 8'h0C;
  localparam logic [7:0] PAR_RST  = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h2C;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [7:0] RD_ZERO  = 8'h00;

  // parity_break_control bit positions
  localparam int PB_PAR_DIS   = 6;
  localparam int PB_BREAK_GENERATION_DISABLE_DS = 5;
  localparam int PB_BREAK_DETECTION_DISABLE_DS = 4;
  localparam int PB_RETRANSMIT_ON_BREAK    = 3;
  localparam int PB_DISCARD   = 2;
  localparam int PB_INS_PE    = 1;
  localparam int PB_FORCE_PE  = 0;
  // character_ts_control bit positions
  localparam int BC_DET_TS    = 6;
  localparam int BC_DIR       = 5;
  localparam int BC_LEN_HI    = 4;
  localparam int BC_LEN_LO    = 3;
  // status bit positions
  localparam int ST_BUSY      = 0;
  localparam int ST_RX_PERR   = 1;
  localparam int ST_CARD_BRK  = 2;

  // -------------------------------------------------------------------------
  // timing, counted in half ETU from the start bit edge
  // -------------------------------------------------------------------------
  localparam int ETU_HALF_TICKS_INT   = 372; // divider ticks per half ETU, 186 card clocks
  localparam logic [8:0] ETU_HALF_TICKS = 9'(ETU_HALF_TICKS_INT);
  localparam int BRK_START_ETU_X10    = 105; // 10.5 ETU
  localparam int BRK_SAMPLE_ETU_X10   = 110; // 11 ETU
  localparam int TX_END_ETU_X10       = 100; // parity bit done
  localparam int RX_END_ETU_X10       = 110;
  localparam int CHAR_END_ETU_X10     = 130; // guard before next char
  localparam logic [4:0] H_BRK_START  = 5'(BRK_START_ETU_X10 * 2 / 10);
  localparam logic [4:0] H_BRK_SAMPLE = 5'(BRK_SAMPLE_ETU_X10 * 2 / 10);
  localparam logic [4:0] H_TX_END     = 5'(TX_END_ETU_X10 * 2 / 10);
  localparam logic [4:0] H_RX_END     = 5'(RX_END_ETU_X10 * 2 / 10);
  localparam logic [4:0] H_CHAR_END   = 5'(CHAR_END_ETU_X10 * 2 / 10);
  localparam logic [4:0] H_ONE        = 5'h01;
  localparam logic [4:0] H_SAMPLE_LO  = 5'h02; // first data bit midpoint - 1
  localparam logic [4:0] H_SAMPLE_HI  = 5'h12; // parity bit midpoint - 1
  localparam logic [3:0] SLOT_PARITY  = 4'h9;
  localparam logic [4:0] H_LEN_1      = 5'h02; // 1 ETU
  localparam logic [4:0] H_LEN_15     = 5'h03; // 1.5 ETU
  localparam logic [4:0] H_LEN_2      = 5'h04; // 2 ETU

  // raw line byte (first bit in bit 0) of TS in indirect convention
  localparam logic [7:0] TS_INDIRECT_RAW = 8'h03;

  // -------------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SC_IDLE = 3'b000,
    SC_TX   = 3'b001,
    SC_TCHK = 3'b011,
    SC_RX   = 3'b010,
    SC_BRK  = 3'b110,
    SC_WAIT = 3'b111
  } scpb_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       perr;
  } scpb_rx_type;

endpackage : scpb_pkg

// >>> rtl/scpb_ctrl.sv
// smart card clock divider, parity, break and TS convention control
`timescale 1ns/1ps
`default_nettype none

module scpb_ctrl (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  input  wire logic [15:0]          addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output var  logic [7:0]           rdata_o,
  input  wire logic                 tx_valid_i,
  input  wire logic [7:0]           tx_data_i,
  output var  logic                 tx_ready_o,
  output var  logic                 rx_valid_o,
  output var  scpb_pkg::scpb_rx_type rx_o,
  input  wire logic                 io_in_i,
  output var  logic                 io_out_o,
  output var  logic                 io_oe_o,
  output var  logic                 sclk_o
);

  // -------------------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------------------
  // convention mapping, its own inverse: direct passes, indirect flips
  // both the bit order and the levels
  function automatic logic [7:0] conv(input logic [7:0] v, input logic dir);
    logic [7:0] r;
    r = v;
    if (!dir) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = ~v[7 - i];
      end
    end
    return r;
  endfunction : conv

  function automatic logic [4:0] brk_halves(input logic [1:0] code);
    logic [4:0] h;
    case (code)
      2'b01:   h = scpb_pkg::H_LEN_15;
      2'b10:   h = scpb_pkg::H_LEN_2;
      default: h = scpb_pkg::H_LEN_1; // reserved code falls back to 1 ETU
    endcase
    return h;
  endfunction : brk_halves

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  logic [5:0] div_field;
  logic [6:0] par_ctl;
  logic       det_ts;
  logic       dir_conv;
  logic [1:0] brk_len;
  logic       prot_t1;
  logic       st_perr;
  logic       st_card_brk;

  logic wr_div;
  logic wr_par;
  logic wr_byte;
  logic wr_prot;
  logic wr_stat;
  assign wr_div  = wr_i && (addr_i == scpb_pkg::ADDR_DIV);
  assign wr_par  = wr_i && (addr_i == scpb_pkg::ADDR_PAR);
  assign wr_byte = wr_i && (addr_i == scpb_pkg::ADDR_BYTE);
  assign wr_prot = wr_i && (addr_i == scpb_pkg::ADDR_PROT);
  assign wr_stat = wr_i && (addr_i == scpb_pkg::ADDR_STAT);

  // decoded settings, taken from the parity and protocol registers
  logic t0;
  logic par_on;
  logic break_generation_disable_on;
  logic break_detection_disable_on;
  assign par_on    = !par_ctl[scpb_pkg::PB_PAR_DIS];
  assign t0        = !prot_t1;
  assign break_generation_disable_on = t0 && !par_ctl[scpb_pkg::PB_BREAK_GENERATION_DISABLE_DS];
  assign break_detection_disable_on = t0 && !par_ctl[scpb_pkg::PB_BREAK_DETECTION_DISABLE_DS];

  // events from the character engine
  logic ts_done;
  logic ts_dir;
  logic rx_eval_perr;
  logic rx_eval;
  logic card_brk_seen;

  // configuration writes
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      div_field <= scpb_pkg::DIV_RST[5:0];
      par_ctl   <= scpb_pkg::PAR_RST[6:0];
      prot_t1   <= scpb_pkg::PROT_RST[0];
      brk_len   <= scpb_pkg::BYTE_RST[scpb_pkg::BC_LEN_HI:scpb_pkg::BC_LEN_LO];
    end else begin
      if (wr_div) div_field <= wdata_i[5:0];
      if (wr_par) par_ctl <= wdata_i[6:0];
      if (wr_prot) prot_t1 <= wdata_i[0];
      if (wr_byte) begin
        brk_len <= wdata_i[scpb_pkg::BC_LEN_HI:scpb_pkg::BC_LEN_LO];
      end
    end
  end

  // detect-TS: a firmware set wins over the hardware clear
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      det_ts <= scpb_pkg::BYTE_RST[scpb_pkg::BC_DET_TS];
    end else if (wr_byte) begin
      det_ts <= wdata_i[scpb_pkg::BC_DET_TS];
    end else if (ts_done) begin
      det_ts <= 1'b0;
    end
  end

  // convention flag: resets to direct, TS result wins over a write
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      // direct until a TS says otherwise
      dir_conv <= scpb_pkg::BYTE_RST[scpb_pkg::BC_DIR];
    end else if (ts_done) begin
      // hardware sets or clears on TS
      dir_conv <= ts_dir;
    end else if (wr_byte) begin
      dir_conv <= wdata_i[scpb_pkg::BC_DIR];
    end
  end

  // sticky status, write one to clear, new event wins
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_perr     <= 1'b0;
      st_card_brk <= 1'b0;
    end else begin
      if (rx_eval && rx_eval_perr) begin
        st_perr <= 1'b1;
      end else if (wr_stat && wdata_i[scpb_pkg::ST_RX_PERR]) begin
        st_perr <= 1'b0;
      end
      if (card_brk_seen) begin
        st_card_brk <= 1'b1;
      end else if (wr_stat && wdata_i[scpb_pkg::ST_CARD_BRK]) begin
        st_card_brk <= 1'b0;
      end
    end
  end

  scpb_pkg::scpb_state_type state;

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_o <= scpb_pkg::RD_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        scpb_pkg::ADDR_DIV:  rdata_o <= {2'b00, div_field};
        scpb_pkg::ADDR_PAR:  rdata_o <= {1'b0, par_ctl};
        scpb_pkg::ADDR_BYTE: rdata_o <= {1'b0, det_ts, dir_conv, brk_len,
                                         scpb_pkg::BYTE_RST[2:0]};
        scpb_pkg::ADDR_PROT: rdata_o <= {7'h00, prot_t1};
        scpb_pkg::ADDR_STAT: rdata_o <= {5'h00, st_card_brk, st_perr,
                                         state != scpb_pkg::SC_IDLE};
        default:             rdata_o <= scpb_pkg::RD_ZERO;
      endcase
    end else begin
      rdata_o <= scpb_pkg::RD_ZERO;
    end
  end

  // -------------------------------------------------------------------------
  // card clock divider
  // -------------------------------------------------------------------------
  logic [5:0] div_eff;
  logic [5:0] div_act;
  logic [5:0] pre_cnt;
  logic       msclk_tick;
  assign div_eff = (div_field == 6'h00) ? 6'h01 : div_field;

  // the divisor is only taken at the end of a period, so a write can never
  // cut a card clock phase short
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      pre_cnt    <= 6'h00;
      div_act    <= scpb_pkg::DIV_RST[5:0];
      msclk_tick <= 1'b0;
    end else if (pre_cnt >= div_act) begin
      pre_cnt    <= 6'h00;
      div_act    <= div_eff;
      msclk_tick <= 1'b1;
    end else begin
      pre_cnt    <= pre_cnt + 6'h01;
      msclk_tick <= 1'b0;
    end
  end

  // further divide by two for the card clock
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sclk_o <= 1'b0;
    end else if (msclk_tick) begin
      sclk_o <= ~sclk_o;
    end
  end

  // -------------------------------------------------------------------------
  // half-ETU time base, restarted at every character start
  // -------------------------------------------------------------------------
  logic [8:0] etu_pre;
  logic       half_tick;
  logic [4:0] hcnt;
  logic       restart;
  logic       line_prev;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart) begin
      etu_pre   <= 9'h000;
      half_tick <= 1'b0;
    end else if (msclk_tick && etu_pre == scpb_pkg::ETU_HALF_TICKS - 9'h001) begin
      etu_pre   <= 9'h000;
      half_tick <= 1'b1;
    end else begin
      etu_pre   <= msclk_tick ? etu_pre + 9'h001 : etu_pre;
      half_tick <= 1'b0;
    end
  end

  // saturating count of half ETU since the start edge
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || restart) begin
      hcnt <= 5'h00;
    end else if (half_tick && hcnt != 5'h1F) begin
      hcnt <= hcnt + 5'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      line_prev <= 1'b1;
    end else begin
      line_prev <= io_in_i;
    end
  end

  // true in the cycle where the count moves on to the given half ETU
  function automatic logic at_half(input logic tick, input logic [4:0] cnt,
                                   input logic [4:0] h);
    return tick && (cnt == h - scpb_pkg::H_ONE);
  endfunction : at_half

  // -------------------------------------------------------------------------
  // character engine
  // -------------------------------------------------------------------------
  logic [7:0] tx_hold;   // last character, kept for retransmission
  logic [7:0] tx_line;
  logic       tx_lpar;
  logic [8:0] rx_sh;
  logic [4:0] brk_end;
  logic       retx;
  logic [7:0] rx_raw;
  logic       rx_dir;
  logic [7:0] rx_logic;
  logic       rx_lpar;
  logic [7:0] tx_logic_p;

  // TS decides its own convention; otherwise the flag in force is used
  assign rx_raw   = rx_sh[7:0];
  assign rx_dir   = det_ts ? (rx_raw != scpb_pkg::TS_INDIRECT_RAW) : dir_conv;
  assign rx_logic = conv(rx_raw, rx_dir);
  assign rx_lpar  = rx_dir ? rx_sh[8] : ~rx_sh[8];
  assign tx_logic_p = tx_hold;
  // forced error; even parity over data and parity
  assign rx_eval_perr = par_ctl[scpb_pkg::PB_FORCE_PE] ||
                        (par_on && ((^rx_logic) ^ rx_lpar));
  assign rx_eval  = (state == scpb_pkg::SC_RX) &&
                    at_half(half_tick, hcnt, scpb_pkg::H_BRK_START);
  assign ts_done  = rx_eval && det_ts;
  assign ts_dir   = rx_dir;
  // card break sampled at 11 ETU
  assign card_brk_seen = (state == scpb_pkg::SC_TCHK) && break_detection_disable_on &&
                         at_half(half_tick, hcnt, scpb_pkg::H_BRK_SAMPLE) &&
                         !io_in_i;
  assign restart  = (state == scpb_pkg::SC_IDLE &&
                     ((tx_valid_i && tx_ready_o) || (line_prev && !io_in_i))) ||
                    (state == scpb_pkg::SC_TCHK && retx &&
                     at_half(half_tick, hcnt, scpb_pkg::H_CHAR_END));

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state      <= scpb_pkg::SC_IDLE;
      tx_ready_o <= 1'b0;
      tx_hold    <= 8'h00;
      tx_line    <= 8'h00;
      tx_lpar    <= 1'b1;
      rx_sh      <= 9'h000;
      brk_end    <= 5'h00;
      retx       <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_o       <= '0;
    end else begin
      rx_valid_o <= 1'b0;
      case (state)
        scpb_pkg::SC_IDLE: begin
          tx_ready_o <= 1'b1;
          retx       <= 1'b0;
          if (tx_valid_i && tx_ready_o) begin
            tx_ready_o <= 1'b0;
            tx_hold    <= tx_data_i;
            tx_line    <= conv(tx_data_i, dir_conv);
            tx_lpar    <= dir_conv ^ ~((^tx_data_i) ^
                          par_ctl[scpb_pkg::PB_INS_PE]);
            state      <= scpb_pkg::SC_TX;
          end else if (line_prev && !io_in_i) begin
            tx_ready_o <= 1'b0;
            state      <= scpb_pkg::SC_RX;
          end
        end
        scpb_pkg::SC_TX: begin
          if (at_half(half_tick, hcnt, scpb_pkg::H_TX_END)) begin
            state <= scpb_pkg::SC_TCHK;
          end
        end
        scpb_pkg::SC_TCHK: begin
          // card break sampled after our character
          if (card_brk_seen) begin
            retx <= par_ctl[scpb_pkg::PB_RETRANSMIT_ON_BREAK];
          end
          if (at_half(half_tick, hcnt, scpb_pkg::H_CHAR_END)) begin
            if (retx) begin
              tx_line <= conv(tx_logic_p, dir_conv);
              retx    <= 1'b0;
              state   <= scpb_pkg::SC_TX;
            end else begin
              state   <= scpb_pkg::SC_IDLE;
            end
          end
        end
        scpb_pkg::SC_RX: begin
          if (at_half(half_tick, hcnt, scpb_pkg::H_ONE) && io_in_i) begin
            state <= scpb_pkg::SC_IDLE; // glitch, not a start bit
          end else if (half_tick && !hcnt[0] && hcnt >= scpb_pkg::H_SAMPLE_LO &&
                       hcnt <= scpb_pkg::H_SAMPLE_HI) begin
            rx_sh <= {io_in_i, rx_sh[8:1]};
          end else if (rx_eval) begin
            rx_o.data <= rx_logic;
            rx_o.perr <= rx_eval_perr;
            // drop a bad character in T=0 with checking and discard on
            rx_valid_o <= !(rx_eval_perr && t0 && par_on &&
                            par_ctl[scpb_pkg::PB_DISCARD]);
            brk_end <= scpb_pkg::H_BRK_START + brk_halves(brk_len);
            // break only with parity checking on
            if (rx_eval_perr && par_on && break_generation_disable_on) begin
              state <= scpb_pkg::SC_BRK;
            end else begin
              state <= scpb_pkg::SC_WAIT;
            end
          end
        end
        scpb_pkg::SC_BRK: begin
          if (at_half(half_tick, hcnt, brk_end)) begin
            state <= scpb_pkg::SC_WAIT;
          end
        end
        scpb_pkg::SC_WAIT: begin
          if (hcnt >= scpb_pkg::H_RX_END) begin
            state <= scpb_pkg::SC_IDLE;
          end
        end
        default: state <= scpb_pkg::SC_IDLE;
      endcase
    end
  end

  // open drain line: only ever pulled low, released otherwise
  logic [3:0] slot;
  logic       tx_low;
  assign slot = hcnt[4:1];
  always_comb begin
    tx_low = 1'b0;
    if (slot == 4'h0) begin
      tx_low = 1'b1;
    end else if (slot <= 4'h8) begin
      tx_low = !tx_line[3'(slot - 4'h1)];
    end else if (slot == scpb_pkg::SLOT_PARITY) begin
      tx_low = !tx_lpar;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      io_oe_o  <= 1'b0;
      io_out_o <= 1'b0;
    end else begin
      io_out_o <= 1'b0;
      io_oe_o  <= (state == scpb_pkg::SC_TX && tx_low) ||
                  (state == scpb_pkg::SC_BRK);
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence brk_entry;
    state == scpb_pkg::SC_RX ##1 state == scpb_pkg::SC_BRK;
  endsequence

  sclk_on_tick_a: assert property (
    sclk_o != $past(sclk_o) |-> $past(msclk_tick))
    else $error("card clock moved without a divider tick");

  div_reset_a: assert property (disable iff (1'b0)
    !reset_n_i |=> div_field == 6'h0C && div_act == 6'h0C)
    else $error("divisor not at default after reset");

  div_zero_a: assert property (
    msclk_tick |-> !$past(msclk_tick) || div_act != 6'h00)
    else $error("divisor zero not treated as one");

  brk_cause_a: assert property (
    brk_entry |-> $past(rx_eval_perr) && $past(par_on) && $past(break_generation_disable_on))
    else $error("break without parity error or with checking off");

  brk_start_a: assert property (
    brk_entry |-> hcnt == scpb_pkg::H_BRK_START ##1 io_oe_o)
    else $error("break did not start at 10.5 ETU");

  ts_clear_a: assert property (
    ts_done && !wr_byte |=> !det_ts && dir_conv == $past(ts_dir))
    else $error("TS did not clear detect bit or set convention");

  discard_a: assert property (
    rx_valid_o |-> !(rx_o.perr && t0 && par_on &&
                     par_ctl[scpb_pkg::PB_DISCARD]))
    else $error("bad character kept while discard enabled");

  retx_a: assert property (
    state == scpb_pkg::SC_TCHK && retx && half_tick &&
    hcnt == scpb_pkg::H_CHAR_END - scpb_pkg::H_ONE
    |=> state == scpb_pkg::SC_TX && hcnt == 5'h00)
    else $error("card break did not restart transmission");

endmodule : scpb_ctrl

`default_nettype wire

// >>> verification/scpb_card_model.sv
// card-side model of the smart card I/O line, open drain only
`timescale 1ns/1ps
`default_nettype none

module scpb_card_model #(
  parameter int ETU = 1488
) (
  input  wire logic       clk_i,
  input  wire logic       io_i,
  input  wire logic       send_i,
  input  wire logic       brk_i,
  input  wire logic [8:0] char_i,
  output var  logic       pull_o,
  output var  logic       got_o,
  output var  logic [8:0] char_o
);
  // ---------------------------------------------------------------
  // one frame at a time; a released line idles high by the pull-up
  // ---------------------------------------------------------------
  logic [9:0] frame;
  logic       brk;

  initial begin
    pull_o = 1'b0;
    got_o  = 1'b0;
    char_o = 9'h000;
  end

  // send {parity, data} after a start bit, or sample what the device sends
  always begin
    @(posedge clk_i);
    if (send_i) begin
      frame = {char_i, 1'b0};
      for (int i = 0; i < 10; i++) begin
        pull_o <= ~frame[i];
        repeat (ETU) @(posedge clk_i);
      end
      pull_o <= 1'b0;
      // deaf meanwhile, so the device's own error break is no start bit
      repeat (3 * ETU) @(posedge clk_i);
    end else if (!io_i) begin
      repeat (ETU + ETU / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        char_o[i] <= io_i; // bit 8 is the parity bit
        repeat (ETU) @(posedge clk_i);
      end
      brk = brk_i;
      if (brk) begin
        // error signal: line held low across the 11 ETU sample
        pull_o <= 1'b1;
        repeat (ETU) @(posedge clk_i);
        pull_o <= 1'b0;
      end
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
      // after a break stay short of the 13 ETU resend
      repeat (brk ? ETU / 4 : 2 * ETU) @(posedge clk_i);
    end
  end
endmodule : scpb_card_model
`default_nettype wire

// >>> verification/scpb_ctrl_bench.sv
// self-checking bench of the smart card parity and break control
`timescale 1ns/1ps
`default_nettype none

module scpb_ctrl_bench;
  localparam int ETU = 1488; // mclk per ETU at divisor 0 or 1
  logic                  mclk      = 1'b0;
  logic                  reset_n   = 1'b0;
  logic [15:0]           addr      = 16'h0000;
  logic [7:0]            wdata     = 8'h00;
  logic                  wr        = 1'b0;
  logic                  rd        = 1'b0;
  logic                  tx_valid  = 1'b0;
  logic [7:0]            tx_data   = 8'h00;
  logic                  send      = 1'b0;
  logic                  card_brk  = 1'b0;
  logic [8:0]            card_char = 9'h000;
  logic                  rd_q      = 1'b0;
  logic [7:0]            rdata;
  logic                  tx_ready;
  logic                  rx_valid;
  scpb_pkg::scpb_rx_type rx;
  logic                  io_oe;
  logic                  sclk;
  logic                  pull;
  logic                  got;
  logic [8:0]            got_char;
  wire                   io_line = ~(io_oe | pull);
  int                    bad_count = 0;
  int                    n_compared = 0;
  int                    n;
  logic [8:0]            notes[$];
  logic [7:0]            d;
  time                   t0;

  always #20 mclk = ~mclk;

  scpb_ctrl i_scpb_ctrl (.mclk_i(mclk), .reset_n_i(reset_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_o(rx), .io_in_i(io_line), .io_out_o(),
    .io_oe_o(io_oe), .sclk_o(sclk));

  scpb_card_model #(.ETU(ETU)) i_scpb_card_model (.clk_i(mclk),
    .io_i(io_line), .send_i(send), .brk_i(card_brk), .char_i(card_char),
    .pull_o(pull),
    .got_o(got), .char_o(got_char));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [8:0] e,
                       input logic [8:0] s);
    n_compared++;
    if (e !== s) begin
      $display("unexpected %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : check

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] v);
    notes.push_back({1'b0, v});
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask : reg_rd

  task automatic sclk_period(input logic [8:0] e);
    repeat (3) @(posedge sclk);
    t0 = $time;
    @(posedge sclk);
    check("sclk period", e, 9'(($time - t0) / 40));
  endtask : sclk_period

  // counts edges until the line drive reaches the wanted level
  task automatic wait_oe(input logic lvl);
    n = 0;
    while (io_oe !== lvl && n < 50000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : wait_oe

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // watcher: oldest note against each result as it appears
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    rd_q <= rd;
    if (rd_q) check("rdata", notes.pop_front(), {1'b0, rdata});
    if (rx_valid) check("rx char", notes.pop_front(), {rx.data, rx.perr});
    if (got) check("card char", notes.pop_front(), got_char);
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h2A7E));
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    reg_rd(scpb_pkg::ADDR_DIV, 8'h0C);
    reg_rd(scpb_pkg::ADDR_PAR, 8'h00);
    reg_rd(scpb_pkg::ADDR_BYTE, 8'h2C);
    reg_rd(16'hFE1F, 8'h00);
    $display("test reset values done");
    sclk_period(9'h01A);
    reg_wr(scpb_pkg::ADDR_DIV, 8'h00);
    sclk_period(9'h004);
    reg_wr(scpb_pkg::ADDR_DIV, 8'h01);
    sclk_period(9'h004);
    reg_rd(scpb_pkg::ADDR_DIV, 8'h01);
    $display("test clock divider done");
    // direct convention, 1.5 ETU break, all checks on, T=0
    reg_wr(scpb_pkg::ADDR_BYTE, 8'h28);
    reg_wr(scpb_pkg::ADDR_PAR, 8'h00);
    d = 8'($urandom);
    notes.push_back({d, 1'b1});
    @(posedge mclk);
    card_char <= {~^d, d};
    send      <= 1'b1;
    @(posedge mclk);
    send <= 1'b0;
    wait_oe(1'b1);
    check("break start", 9'h001, 9'(n >= 15624 && n <= 15632));
    wait_oe(1'b0);
    check("break length", 9'h001, 9'(n >= 2230 && n <= 2234));
    repeat (2 * ETU) @(posedge mclk);
    $display("test receive break done");
    reg_wr(scpb_pkg::ADDR_PAR, 8'h02);
    d = 8'($urandom);
    notes.push_back({~^d, d});
    tx_data  <= d;
    tx_valid <= 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    repeat (13 * ETU + 100) @(posedge mclk);
    $display("test transmit parity done");
    // card break after our character: the character goes out twice
    reg_wr(scpb_pkg::ADDR_PAR, 8'h08);
    d = 8'($urandom);
    notes.push_back({^d, d});
    notes.push_back({^d, d});
    card_brk <= 1'b1;
    tx_data  <= d;
    tx_valid <= 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
    @(posedge got);
    card_brk <= 1'b0;
    repeat (15 * ETU) @(posedge mclk);
    reg_rd(scpb_pkg::ADDR_STAT, 8'h06);
    $display("test card break done");
    end_of_test();
  end

  // watchdog, a little beyond the planned run
  initial begin
    repeat (95000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end
endmodule : scpb_ctrl_bench
`default_nettype wire
